// ==== hw/external_function_sense_port.sv ====
// Computer side of the external function and sense lines for four cable groups
//
// How it works
// - Output sense strobe drops itself after 12.8 us
// - Sense line captured as the strobe ends
// - Code bit zero set inverts the captured answer
// - Channel 7 transfer; odd inputs, even outputs
// - Input strobes only on buffer groups; group 3 actives both follow channel 7
// - Input sense strobe drops itself after 12.8 us
// - Function ready strobes drop after 12.8 us
`timescale 1ns/1ps
`include "efs_defs.svh"

module external_function_sense_port (
  input  wire logic                         clock_in,           // System clock
  input  wire logic                         rst_b_in,           // Sync reset, active low
  input  wire logic                         cmd_valid_in,       // Request present
  input  wire efs_pkg::cmd_kind_type        cmd_kind_in,        // Function or sense kind
  input  wire logic [1:0]                   cmd_group_in,       // Target cable group
  input  wire logic [`EFS_CODE_W-1:0]       cmd_code_in,        // 12-bit function code
  output logic                              cmd_ready_out,      // Sequencer can take request
  output logic                              cmd_error_out,      // Pulse: request refused
  output logic                              sense_done_out,     // Pulse: sense result valid
  output logic                              sense_result_out,   // Condition present
  input  wire logic [6:0]                   chan_active_in,     // Channel 1..7 active
  input  wire logic                         master_clear_in,    // Console clear switch
  input  wire logic [`EFS_GROUPS-1:0]       sense_response_in,  // Sense line per group
  output logic [`EFS_GROUPS*`EFS_CODE_W-1:0] func_lines_out,    // Function lines, group-major
  output logic [`EFS_GROUPS-1:0]            in_func_ready_out,  // Input function ready
  output logic [`EFS_GROUPS-1:0]            out_func_ready_out, // Output function ready
  output logic [`EFS_GROUPS-1:0]            in_sense_ready_out, // Input sense ready
  output logic [`EFS_GROUPS-1:0]            out_sense_ready_out,// Output sense ready
  output logic [`EFS_GROUPS-1:0]            in_active_out,      // Input buffer/transfer active
  output logic [`EFS_GROUPS-1:0]            out_active_out,     // Output buffer active
  output logic [`EFS_GROUPS-1:0]            master_clear_out    // External master clear
);

  import efs_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // One-hot strobe select: bit0 in func, 1 out func, 2 in sense, 3 out sense
  function automatic logic [3:0] strobe_sel(input cmd_kind_type kind);
    logic [3:0] sel;
    sel = 4'h0;
    case (kind)
      KIND_IN_FUNC:   sel = 4'h1;
      KIND_OUT_FUNC:  sel = 4'h2;
      KIND_IN_SENSE:  sel = 4'h4;
      KIND_OUT_SENSE: sel = 4'h8;
      default:        sel = 4'h0;
    endcase
    return sel;
  endfunction : strobe_sel

  // True for kinds that exist only on buffer groups
  function automatic logic is_input_kind(input cmd_kind_type kind);
    return (kind == KIND_IN_FUNC) || (kind == KIND_IN_SENSE);
  endfunction : is_input_kind

  ////////////////////////////////////////////////////////////////////////
  // State

  state_type                          state_r;        // Sequencer state
  state_type                          state_nxt;      // Next state
  cmd_kind_type                       kind_r;         // Kind being served
  cmd_kind_type                       kind_nxt;       // Next kind
  logic [1:0]                         group_r;        // Group being served
  logic [1:0]                         group_nxt;      // Next group
  logic [`EFS_CODE_W-1:0]             code_r;         // Code being served
  logic [`EFS_CODE_W-1:0]             code_nxt;       // Next code
  logic [`EFS_GROUPS*`EFS_CODE_W-1:0] lines_r;        // Function lines
  logic [`EFS_GROUPS*`EFS_CODE_W-1:0] lines_nxt;      // Next function lines
  logic [3:0]                         strb_r [`EFS_GROUPS]; // Strobes per group
  logic [3:0]                         strb_nxt [`EFS_GROUPS]; // Next strobes
  logic                               ready_r;        // Request ready
  logic                               ready_nxt;      // Next ready
  logic                               err_r;          // Refusal pulse
  logic                               err_nxt;        // Next refusal
  logic                               done_r;         // Sense done pulse
  logic                               done_nxt;       // Next sense done
  logic                               result_r;       // Sense result
  logic                               result_nxt;     // Next sense result
  logic                               timer_start;    // Start strobe period
  logic                               timer_expired;  // Last strobe cycle
  logic                               take;           // Request accepted
  logic                               refuse;         // Request refused

  ////////////////////////////////////////////////////////////////////////
  // Strobe length counter

  strobe_timer u_timer (
    .clock_in    (clock_in),
    .rst_b_in    (rst_b_in),
    .start_in    (timer_start),
    .expired_out (timer_expired)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: load code, raise strobe, time it, capture sense

  // Input kinds aimed at the transfer group are refused
  assign refuse = cmd_valid_in && ready_r && is_input_kind(cmd_kind_in) &&
                  (cmd_group_in == `EFS_XFER_GROUP);
  assign take   = cmd_valid_in && ready_r && !refuse;

  // Next sequencer values
  always_comb begin
    state_nxt   = state_r;
    kind_nxt    = kind_r;
    group_nxt   = group_r;
    code_nxt    = code_r;
    lines_nxt   = lines_r;
    err_nxt     = refuse;
    done_nxt    = 1'b0;
    result_nxt  = result_r;
    timer_start = 1'b0;
    for (int g = 0; g < `EFS_GROUPS; g++) begin
      strb_nxt[g] = strb_r[g];
    end
    case (state_r)
      ST_IDLE: begin
        if (take) begin
          // Code goes on the lines one cycle before the strobe
          kind_nxt  = cmd_kind_in;
          group_nxt = cmd_group_in;
          code_nxt  = cmd_code_in;
          lines_nxt[cmd_group_in*`EFS_CODE_W +: `EFS_CODE_W] = cmd_code_in;
          state_nxt = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // Raise the selected strobe and start its period
        strb_nxt[group_r] = strobe_sel(kind_r);
        timer_start       = 1'b1;
        state_nxt         = ST_STROBE;
      end
      ST_STROBE: begin
        // Lines left untouched while the strobe is up
        if (timer_expired) begin
          strb_nxt[group_r] = 4'h0;
          state_nxt         = ST_IDLE;
          if ((kind_r == KIND_IN_SENSE) || (kind_r == KIND_OUT_SENSE)) begin
            // Sample as the strobe ends, invert on odd code
            result_nxt = sense_response_in[group_r] ^ code_r[`EFS_INV_BIT];
            done_nxt   = 1'b1;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    ready_nxt = (state_nxt == ST_IDLE);
  end

  // Register the sequencer
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      state_r  <= ST_IDLE;
      kind_r   <= KIND_IN_FUNC;
      group_r  <= 2'h0;
      code_r   <= `EFS_CODE_RST;
      lines_r  <= '0;
      ready_r  <= 1'b0;
      err_r    <= 1'b0;
      done_r   <= 1'b0;
      result_r <= 1'b0;
      for (int g = 0; g < `EFS_GROUPS; g++) begin
        strb_r[g] <= 4'h0;
      end
    end else begin
      state_r  <= state_nxt;
      kind_r   <= kind_nxt;
      group_r  <= group_nxt;
      code_r   <= code_nxt;
      lines_r  <= lines_nxt;
      ready_r  <= ready_nxt;
      err_r    <= err_nxt;
      done_r   <= done_nxt;
      result_r <= result_nxt;
      for (int g = 0; g < `EFS_GROUPS; g++) begin
        strb_r[g] <= strb_nxt[g];
      end
    end
  end

  assign cmd_ready_out    = ready_r;
  assign cmd_error_out    = err_r;
  assign sense_done_out   = done_r;
  assign sense_result_out = result_r;
  assign func_lines_out   = lines_r;

  ////////////////////////////////////////////////////////////////////////
  // Per-group strobes, channel actives and master clear

  logic [`EFS_GROUPS-1:0] in_act_r;    // Input or transfer active
  logic [`EFS_GROUPS-1:0] in_act_nxt;  // Next input active
  logic [`EFS_GROUPS-1:0] out_act_r;   // Output buffer active
  logic [`EFS_GROUPS-1:0] out_act_nxt; // Next output active
  logic [`EFS_GROUPS-1:0] mclr_r;      // Master clear per group
  logic [`EFS_GROUPS-1:0] mclr_nxt;    // Next master clear

  // Map channels onto each group's active lines, one process for all groups
  always_comb begin
    for (int g = 0; g < `EFS_GROUPS; g++) begin
      mclr_nxt[g] = master_clear_in;
      if (g == `EFS_XFER_GROUP) begin
        in_act_nxt[g]  = chan_active_in[`EFS_XFER_CHAN];
        out_act_nxt[g] = chan_active_in[`EFS_XFER_CHAN];
      end else begin
        in_act_nxt[g]  = chan_active_in[2*g];
        out_act_nxt[g] = chan_active_in[2*g+1];
      end
    end
  end

  // Strobe outputs per group, straight from the strobe flops
  genvar gi;
  generate
    for (gi = 0; gi < `EFS_GROUPS; gi++) begin : g_grp
      assign in_func_ready_out[gi]   = strb_r[gi][0];
      assign out_func_ready_out[gi]  = strb_r[gi][1];
      assign in_sense_ready_out[gi]  = strb_r[gi][2];
      assign out_sense_ready_out[gi] = strb_r[gi][3];
    end
  endgenerate

  // Register group status lines
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      in_act_r  <= '0;
      out_act_r <= '0;
      mclr_r    <= '0;
    end else begin
      in_act_r  <= in_act_nxt;
      out_act_r <= out_act_nxt;
      mclr_r    <= mclr_nxt;
    end
  end

  assign in_active_out    = in_act_r;
  assign out_active_out   = out_act_r;
  assign master_clear_out = mclr_r;

endmodule : external_function_sense_port

// ==== hw/efs_defs.svh ====
// Constants for the external function and sense port
`ifndef EFS_DEFS_SVH
`define EFS_DEFS_SVH

`define EFS_CLK_PERIOD_NS  4                // Clock period in ns
`define EFS_STROBE_NS      12800            // Strobe length in ns
`define EFS_STROBE_CYCLES  ((`EFS_STROBE_NS + `EFS_CLK_PERIOD_NS - 1) / `EFS_CLK_PERIOD_NS)
`define EFS_CNT_W          12               // Strobe counter width
`define EFS_CODE_W         12               // Function code width
`define EFS_GROUPS         4                // Number of cable groups
`define EFS_XFER_GROUP     2'h3             // Group that carries the transfer channel
`define EFS_XFER_CHAN      3'h6             // Index of channel 7 in the active vector
`define EFS_INV_BIT        0                // Code bit that asks for inverted sense
`define EFS_CODE_RST       12'h000          // Function lines after reset

`endif

// ==== hw/efs_pkg.sv ====
// Types for the external function and sense port
package efs_pkg;

  // Kind of request on the function lines
  typedef enum logic [1:0] {
    KIND_IN_FUNC,
    KIND_OUT_FUNC,
    KIND_IN_SENSE,
    KIND_OUT_SENSE
  } cmd_kind_type;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE
  } state_type;

endpackage : efs_pkg

// ==== hw/strobe_timer.sv ====
// Self-timed strobe length counter
`timescale 1ns/1ps
`include "efs_defs.svh"

module strobe_timer (
  input  wire logic clock_in,     // System clock
  input  wire logic rst_b_in,     // Synchronous reset, active low
  input  wire logic start_in,     // Pulse: begin a strobe period
  output logic      expired_out   // High in the last cycle of the period
);

  logic [`EFS_CNT_W-1:0] cnt_r;      // Cycles left in the period
  logic [`EFS_CNT_W-1:0] cnt_nxt;    // Next count
  logic                  run_r;      // Period in progress
  logic                  run_nxt;    // Next run flag

  assign expired_out = run_r && (cnt_r == '0);

  ////////////////////////////////////////////////////////////////////////
  // Next count: load on start, count down, stop at zero
  always_comb begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    if (start_in) begin
      cnt_nxt = `EFS_CNT_W'(`EFS_STROBE_CYCLES - 1);
      run_nxt = 1'b1;
    end else if (expired_out) begin
      run_nxt = 1'b0;              // Period over
    end else if (run_r) begin
      cnt_nxt = cnt_r - 1'b1;      // Still counting
    end
  end

  // Register the counter
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
    end
  end

endmodule : strobe_timer

// ==== sim/efs_port_chk.sv ====
// Property checker for the function and sense port
`timescale 1ns/1ps
`include "efs_defs.svh"
module efs_port_chk (
  input wire logic                           clock_in,            // Clock
  input wire logic                           rst_b_in,            // Reset, active low
  input wire logic                           cmd_valid_in,        // Request present
  input wire efs_pkg::cmd_kind_type          cmd_kind_in,         // Request kind
  input wire logic [1:0]                     cmd_group_in,        // Target group
  input wire logic                           cmd_ready_out,       // Idle
  input wire logic                           cmd_error_out,       // Refusal pulse
  input wire logic                           sense_done_out,      // Result pulse
  input wire logic                           sense_result_out,    // Result
  input wire logic [6:0]                     chan_active_in,      // Channel actives
  input wire logic [`EFS_GROUPS-1:0]         sense_response_in,   // Sense lines
  input wire logic [`EFS_GROUPS*`EFS_CODE_W-1:0] func_lines_out,  // Function lines
  input wire logic [`EFS_GROUPS-1:0]         in_func_ready_out,   // Input function strobe
  input wire logic [`EFS_GROUPS-1:0]         out_func_ready_out,  // Output function strobe
  input wire logic [`EFS_GROUPS-1:0]         in_sense_ready_out,  // Input sense strobe
  input wire logic [`EFS_GROUPS-1:0]         out_sense_ready_out, // Output sense strobe
  input wire logic [`EFS_GROUPS-1:0]         in_active_out,       // Input actives
  input wire logic [`EFS_GROUPS-1:0]         out_active_out       // Output actives
);
  import efs_pkg::*;
  localparam int STROBE_LEN = `EFS_STROBE_CYCLES; // Strobe high cycles
  logic [`EFS_CNT_W-1:0] cnt_r, cnt_nxt;          // Cycles a strobe has stood
  logic any_strobe, sense_any, sel_resp, sel_inv; // Decoded views
  logic [3:0] in_map, out_map;                    // Expected active mapping
  ////////////////////////////////////////////////////////////////////////////////
  // Strobe length counter and sense selection
  always_comb begin
    any_strobe = |{in_func_ready_out, out_func_ready_out, in_sense_ready_out, out_sense_ready_out};
    sense_any = |{in_sense_ready_out, out_sense_ready_out};
    in_map = {chan_active_in[6], chan_active_in[4], chan_active_in[2], chan_active_in[0]};
    out_map = {chan_active_in[6], chan_active_in[5], chan_active_in[3], chan_active_in[1]};
    sel_resp = 1'b0;
    sel_inv = 1'b0;
    for (int g = 0; g < `EFS_GROUPS; g++) begin
      if (in_sense_ready_out[g] || out_sense_ready_out[g]) begin // Group being sensed
        sel_resp = sense_response_in[g];
        sel_inv = func_lines_out[g*`EFS_CODE_W+`EFS_INV_BIT];
      end
    end
    cnt_nxt = (rst_b_in && any_strobe) ? cnt_r + 1'b1 : '0;
  end
  always_ff @(posedge clock_in) begin
    cnt_r <= cnt_nxt;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Properties
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_sense_end;
    $fell(sense_any);
  endsequence
  sequence s_take_in_xfer;
    cmd_valid_in && cmd_ready_out && cmd_group_in == `EFS_XFER_GROUP &&
      (cmd_kind_in == KIND_IN_FUNC || cmd_kind_in == KIND_IN_SENSE);
  endsequence
  AST_OSENSE_LEN: assert property ($fell(|out_sense_ready_out) |-> cnt_r == STROBE_LEN)
    else $error("output sense strobe length wrong");
  AST_ISENSE_LEN: assert property ($fell(|in_sense_ready_out) |-> cnt_r == STROBE_LEN)
    else $error("input sense strobe length wrong");
  AST_FUNC_LEN: assert property ($fell(|{in_func_ready_out, out_func_ready_out})
    |-> cnt_r == STROBE_LEN) else $error("function strobe length wrong");
  AST_STROBE_MAX: assert property (any_strobe |-> cnt_r < STROBE_LEN)
    else $error("strobe overran");
  AST_CODE_STABLE: assert property (any_strobe && $past(any_strobe)
    |-> $stable(func_lines_out)) else $error("function lines moved under strobe");
  AST_SENSE_CAPTURE: assert property (s_sense_end |-> sense_done_out &&
    sense_result_out == ($past(sel_resp) ^ $past(sel_inv))) else $error("sense result wrong");
  AST_DONE_CAUSE: assert property (sense_done_out |-> $fell(sense_any))
    else $error("stray sense done");
  AST_XFER_NO_INPUT: assert property (!(in_func_ready_out[3] || in_sense_ready_out[3]))
    else $error("input strobe on transfer group");
  AST_XFER_REFUSE: assert property (s_take_in_xfer |=> cmd_error_out && cmd_ready_out)
    else $error("transfer input request not refused");
  AST_CHAN_MAP: assert property ($past(rst_b_in) |-> in_active_out == $past(in_map) &&
    out_active_out == $past(out_map)) else $error("channel active mapping wrong");
endmodule : efs_port_chk

bind external_function_sense_port efs_port_chk u_chk (.clock_in, .rst_b_in, .cmd_valid_in,
  .cmd_kind_in, .cmd_group_in, .cmd_ready_out, .cmd_error_out, .sense_done_out,
  .sense_result_out, .chan_active_in, .sense_response_in, .func_lines_out, .in_func_ready_out,
  .out_func_ready_out, .in_sense_ready_out, .out_sense_ready_out, .in_active_out, .out_active_out);

// ==== sim/efs_equipment.sv ====
// Behavioural model of the peripheral equipment on the cable groups
`timescale 1ns/1ps
`include "efs_defs.svh"
module efs_equipment (
  input  wire logic                               clock_in,          // System clock
  input  wire logic                               rst_b_in,          // Reset, active low
  input  wire logic [`EFS_GROUPS*`EFS_CODE_W-1:0] func_lines_in,     // Function lines
  input  wire logic [`EFS_GROUPS-1:0]             any_strobe_in,     // Any strobe per group
  input  wire logic [`EFS_GROUPS-1:0]             sense_strobe_in,   // Sense strobe per group
  output logic [`EFS_GROUPS-1:0]                  sense_response_out // Sense lines
);
  logic [`EFS_GROUPS*`EFS_CODE_W-1:0] code_r, code_nxt; // Accepted codes
  logic [`EFS_GROUPS-1:0]             resp_nxt;         // Next sense level
  ////////////////////////////////////////////////////////////////////////////////
  // Code acceptance and condition answer
  always_comb begin
    code_nxt = code_r;
    for (int g = 0; g < `EFS_GROUPS; g++) begin
      if (any_strobe_in[g]) begin // Lines taken only under a strobe
        code_nxt[g*12 +: 12] = func_lines_in[g*12 +: 12];
      end
      // Condition named by code bits 1 and 11, else the line wanders
      resp_nxt[g] = sense_strobe_in[g] ? code_nxt[g*12+1] ^ code_nxt[g*12+11]
                                       : ~sense_response_out[g];
    end
    if (!rst_b_in) begin
      code_nxt = '0;
      resp_nxt = '0;
    end
  end
  always_ff @(posedge clock_in) begin
    code_r <= code_nxt;
    sense_response_out <= resp_nxt;
  end
endmodule : efs_equipment

// ==== sim/external_function_sense_port_tb.sv ====
// Self-checking bench for the function and sense port
`timescale 1ns/1ps
`include "efs_defs.svh"
module external_function_sense_port_tb;
  import efs_pkg::*;
  typedef struct packed {
    cmd_kind_type kind;  // Request kind
    logic [1:0]   group; // Cable group
    logic [11:0]  code;  // Function code
    logic         err;   // Refusal expected
    logic         res;   // Sense result expected
  } row_type;
  localparam int N_ROWS = 9; // Table size
  localparam row_type ROWS [N_ROWS] = '{
    '{KIND_OUT_SENSE, 2'h0, 12'h002, 1'b0, 1'b1}, '{KIND_OUT_SENSE, 2'h1, 12'h003, 1'b0, 1'b0},
    '{KIND_IN_SENSE, 2'h2, 12'h800, 1'b0, 1'b1}, '{KIND_IN_SENSE, 2'h0, 12'h801, 1'b0, 1'b0},
    '{KIND_OUT_SENSE, 2'h3, 12'h000, 1'b0, 1'b0}, '{KIND_OUT_FUNC, 2'h3, 12'habc, 1'b0, 1'b0},
    '{KIND_IN_FUNC, 2'h1, 12'h5a5, 1'b0, 1'b0}, '{KIND_IN_FUNC, 2'h3, 12'h111, 1'b1, 1'b0},
    '{KIND_IN_SENSE, 2'h3, 12'h222, 1'b1, 1'b0}};
  logic clock_in = 1'b0, rst_b_in = 1'b0, cmd_valid_in = 1'b0, master_clear_in = 1'b0;
  cmd_kind_type cmd_kind_in = KIND_IN_FUNC;     // Request kind
  logic [1:0]   cmd_group_in = 2'h0;            // Request group
  logic [11:0]  cmd_code_in = 12'h000;          // Request code
  logic [6:0]   chan_active_in = 7'h55;         // Channel actives
  logic cmd_ready_out, cmd_error_out, sense_done_out, sense_result_out; // Status
  logic [47:0]  func_lines_out;                 // Function lines
  logic [3:0]   sense_response_in, in_func_ready_out, out_func_ready_out, in_sense_ready_out;
  logic [3:0]   out_sense_ready_out, in_active_out, out_active_out, master_clear_out;
  int n_fail = 0, check_count = 0, cycles = 0;  // Tallies
  always #2 clock_in = ~clock_in;
  external_function_sense_port dut (.clock_in, .rst_b_in, .cmd_valid_in, .cmd_kind_in,
    .cmd_group_in, .cmd_code_in, .cmd_ready_out, .cmd_error_out, .sense_done_out,
    .sense_result_out, .chan_active_in, .master_clear_in, .sense_response_in, .func_lines_out,
    .in_func_ready_out, .out_func_ready_out, .in_sense_ready_out, .out_sense_ready_out,
    .in_active_out, .out_active_out, .master_clear_out);
  efs_equipment u_equip (.clock_in, .rst_b_in, .func_lines_in(func_lines_out),
    .any_strobe_in(in_func_ready_out | out_func_ready_out | in_sense_ready_out |
                   out_sense_ready_out),
    .sense_strobe_in(in_sense_ready_out | out_sense_ready_out),
    .sense_response_out(sense_response_in));
  ////////////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and hang guard
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    if (n_fail == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 40000) begin // Roughly one and a half times the planned run
      n_fail++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One request from a table row, checked through to its end
  task automatic run_row(input row_type r);
    int n;
    logic [3:0] st;
    n = 0;
    cmd_valid_in = 1'b1;
    cmd_kind_in = r.kind;
    cmd_group_in = r.group;
    cmd_code_in = r.code;
    @(negedge clock_in);
    cmd_valid_in = 1'b0;
    check(cmd_error_out, r.err);
    if (r.err) begin
      check(cmd_ready_out, 1'b1);
      @(negedge clock_in);
      return;
    end
    check(func_lines_out[r.group*12 +: 12], r.code);
    for (int i = 0; i < 4000 && cmd_ready_out !== 1'b1; i++) begin
      @(negedge clock_in);
      st = r.kind == KIND_IN_FUNC ? in_func_ready_out : r.kind == KIND_OUT_FUNC ?
           out_func_ready_out : r.kind == KIND_IN_SENSE ? in_sense_ready_out : out_sense_ready_out;
      if (st[r.group] === 1'b1) n++;
    end
    check(n, `EFS_STROBE_CYCLES);
    check(func_lines_out[r.group*12 +: 12], r.code);
    if (r.kind == KIND_IN_SENSE || r.kind == KIND_OUT_SENSE) begin
      check(sense_done_out, 1'b1);
      check(sense_result_out, r.res);
    end else begin
      check(sense_done_out, 1'b0);
    end
    @(negedge clock_in);
  endtask : run_row
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (4) @(negedge clock_in);
    rst_b_in = 1'b1;
    @(negedge clock_in);
    check(in_active_out, 4'hf);
    check(out_active_out, 4'h8);
    check(master_clear_out, 4'h0);
    for (int k = 0; k < N_ROWS; k++) run_row(ROWS[k]);
    chan_active_in = 7'h2a; // Status lines follow one cycle late
    master_clear_in = 1'b1;
    @(negedge clock_in);
    check(in_active_out, 4'h0);
    check(out_active_out, 4'h7);
    check(master_clear_out, 4'hf);
    cmd_valid_in = 1'b1; // Reset in mid-strobe
    cmd_kind_in = KIND_OUT_SENSE;
    cmd_code_in = 12'h0ff;
    @(negedge clock_in);
    cmd_valid_in = 1'b0;
    repeat (100) @(negedge clock_in);
    rst_b_in = 1'b0;
    repeat (4) @(negedge clock_in);
    check(out_sense_ready_out, 4'h0);
    check({func_lines_out, cmd_ready_out}, 49'h0);
    rst_b_in = 1'b1;
    @(negedge clock_in);
    check(cmd_ready_out, 1'b1);
    run_row(ROWS[3]);
    test_done();
  end
endmodule : external_function_sense_port_tb
